// [hw/fol_params.svh]
`ifndef FOL_PARAMS_SVH
`define FOL_PARAMS_SVH

// Offset register width (deepest variant) and bus width
`define FOL_OFS_W      15
`define FOL_BUS_W      36

// Serial sequence: empty bits 0..14, then full bits 15..29
`define FOL_SER_HALF   5'h0F
`define FOL_SER_LAST   5'h1D

// Offset contents after master reset
`define FOL_OFS_RST    15'h0000

// Memory depth, compared against the fill level
`define FOL_DEPTH      16'h8000

// Parallel pointer: last step and stride per bus width
`define FOL_PTR_LAST36 2'h2
`define FOL_PTR_LAST   2'h3
`define FOL_PTR_INC36  2'h2
`define FOL_PTR_INC    2'h1

// Clock edges from the completing edge to a valid flag
`define FOL_FLAG_LAT   2

`endif

// [hw/fol_pkg.sv]
`include "fol_params.svh"
`default_nettype none

package fol_pkg;

    typedef enum logic [1:0] {
        FOL_W36 = 2'h0,
        FOL_W18 = 2'h1,
        FOL_W9  = 2'h2
    } fol_width_t;

    // Gray steps along idle -> shift -> write -> read -> memory write
    typedef enum logic [2:0] {
        FOL_IDLE   = 3'h0,
        FOL_SHIFT  = 3'h1,
        FOL_PWRITE = 3'h3,
        FOL_PREAD  = 3'h2,
        FOL_MEMW   = 3'h6
    } fol_state_t;

    typedef logic [`FOL_OFS_W-1:0] fol_ofs_t;
    typedef logic [`FOL_BUS_W-1:0] fol_bus_t;

    // Lane 8 carries parity when interspersed, so upper bits move up
    function automatic fol_ofs_t fol_unpack(input fol_bus_t bus,
                                            input logic     par);
        fol_unpack = par ? {bus[15:9], bus[7:0]} : bus[14:0];
    endfunction

    function automatic fol_bus_t fol_pack(input fol_ofs_t v,
                                          input logic     par);
        fol_pack = par ? {20'h0, v[14:8], 1'b0, v[7:0]} : {21'h0, v};
    endfunction

    // Bus word for one step of the parallel offset sequence
    function automatic fol_bus_t fol_word(input fol_width_t w,
                                          input logic       par,
                                          input logic [1:0] ptr,
                                          input fol_ofs_t   e,
                                          input fol_ofs_t   f);
        fol_ofs_t v;
        v = ptr[1] ? f : e;
        if (w == FOL_W9) begin
            fol_word = ptr[0] ? {29'h0, v[14:8]} : {28'h0, v[7:0]};
        end else if (ptr[0]) begin
            fol_word = '0;
        end else begin
            fol_word = fol_pack(v, par);
        end
    endfunction

endpackage

`default_nettype wire

// [hw/fol_link_if.sv]
`default_nettype none

interface fol_link_if;
    logic             load_select_n;
    logic             shift_in_enable_n;
    logic             write_strobe_n;
    logic             read_strobe_n;
    logic             shift_in_bit;
    fol_pkg::fol_bus_t input_bus;
    fol_pkg::fol_bus_t output_bus;

    modport dev (
        input  load_select_n,
        input  shift_in_enable_n,
        input  write_strobe_n,
        input  read_strobe_n,
        input  shift_in_bit,
        input  input_bus,
        output output_bus
    );

    modport host (
        output load_select_n,
        output shift_in_enable_n,
        output write_strobe_n,
        output read_strobe_n,
        output shift_in_bit,
        output input_bus,
        input  output_bus
    );
endinterface

`default_nettype wire

// [hw/fol_host.sv]
`include "fol_params.svh"
`default_nettype none

module fol_host (
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    input  wire fol_pkg::fol_width_t bus_width,
    input  wire logic               parity,
    input  wire logic               pause,
    input  wire logic               start_serial,
    input  wire logic               start_par_write,
    input  wire logic               start_read,
    input  wire logic               start_mem_write,
    input  wire fol_pkg::fol_ofs_t  empty_value,
    input  wire fol_pkg::fol_ofs_t  full_value,
    input  wire fol_pkg::fol_bus_t  mem_data,
    output logic                    busy,
    output logic                    read_done,
    output fol_pkg::fol_ofs_t       read_empty,
    output fol_pkg::fol_ofs_t       read_full,
    fol_link_if.host                link
);
    import fol_pkg::*;

    fol_state_t                   state_reg;
    logic [1:0]                   ptr_reg;
    logic [1:0]                   nptr;
    logic [1:0]                   hlast;
    logic [4:0]                   cnt_reg;
    logic [2*`FOL_OFS_W-1:0]      seq_reg;
    fol_ofs_t                     e_reg;
    fol_ofs_t                     f_reg;
    logic                         cap_valid_reg;
    logic                         cap_last_reg;
    logic [1:0]                   cap_ptr_reg;

    assign hlast = (bus_width == FOL_W36) ? `FOL_PTR_LAST36 : `FOL_PTR_LAST;
    assign nptr  = ptr_reg + ((bus_width == FOL_W36) ? `FOL_PTR_INC36
                                                      : `FOL_PTR_INC);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg              <= FOL_IDLE;
            ptr_reg                <= 2'h0;
            cnt_reg                <= 5'h00;
            seq_reg                <= '0;
            e_reg                  <= '0;
            f_reg                  <= '0;
            busy                   <= 1'b0;
            link.load_select_n     <= 1'b1;
            link.shift_in_enable_n <= 1'b1;
            link.write_strobe_n    <= 1'b1;
            link.read_strobe_n     <= 1'b1;
            link.shift_in_bit      <= 1'b0;
            link.input_bus         <= '0;
        end else if (clk_en) begin
            case (state_reg)
                FOL_IDLE: begin
                    e_reg <= empty_value;
                    f_reg <= full_value;
                    if (start_serial) begin
                        state_reg              <= FOL_SHIFT;
                        busy                   <= 1'b1;
                        cnt_reg                <= 5'h00;
                        seq_reg                <= {full_value, empty_value};
                        link.shift_in_bit      <= empty_value[0]; // RULE_01
                        link.load_select_n     <= 1'b0;
                        link.shift_in_enable_n <= pause;
                    end else if (start_par_write) begin
                        state_reg           <= FOL_PWRITE;
                        busy                <= 1'b1;
                        link.load_select_n  <= 1'b0;
                        link.write_strobe_n <= pause;
                        link.input_bus      <= fol_word(bus_width, parity,
                                               ptr_reg, empty_value,
                                               full_value);
                    end else if (start_read) begin
                        state_reg          <= FOL_PREAD;
                        busy               <= 1'b1;
                        link.load_select_n <= 1'b0;
                        link.read_strobe_n <= pause;
                    end else if (start_mem_write) begin
                        state_reg           <= FOL_MEMW;
                        busy                <= 1'b1;
                        link.write_strobe_n <= 1'b0; // RULE_09
                        link.input_bus      <= mem_data;
                    end
                end
                FOL_SHIFT: begin
                    // Pause by raising enable with load held low
                    if (!link.shift_in_enable_n) begin
                        seq_reg           <= {1'b0, seq_reg[29:1]};
                        link.shift_in_bit <= seq_reg[1];
                        cnt_reg           <= cnt_reg + 5'h01;
                    end
                    if (!link.shift_in_enable_n &&
                        cnt_reg == `FOL_SER_LAST) begin // RULE_02
                        state_reg              <= FOL_IDLE;
                        busy                   <= 1'b0;
                        link.load_select_n     <= 1'b1;
                        link.shift_in_enable_n <= 1'b1;
                    end else begin
                        link.shift_in_enable_n <= pause; // RULE_11
                    end
                end
                FOL_PWRITE: begin
                    if (!link.write_strobe_n) begin
                        ptr_reg        <= nptr; // RULE_18
                        link.input_bus <= fol_word(bus_width, parity, nptr,
                                                   e_reg, f_reg);
                    end
                    if (!link.write_strobe_n && ptr_reg == hlast) begin
                        state_reg           <= FOL_IDLE;
                        busy                <= 1'b0;
                        link.load_select_n  <= 1'b1;
                        link.write_strobe_n <= 1'b1;
                    end else begin
                        link.write_strobe_n <= pause;
                    end
                end
                FOL_PREAD: begin
                    if (!link.read_strobe_n) begin
                        ptr_reg <= nptr;
                    end
                    if (!link.read_strobe_n && ptr_reg == hlast) begin
                        state_reg          <= FOL_IDLE;
                        link.load_select_n <= 1'b1;
                        link.read_strobe_n <= 1'b1;
                    end else begin
                        link.read_strobe_n <= pause;
                    end
                end
                FOL_MEMW: begin
                    state_reg           <= FOL_IDLE;
                    busy                <= 1'b0;
                    link.write_strobe_n <= 1'b1;
                end
                default: begin
                    state_reg <= FOL_IDLE;
                end
            endcase
            if (cap_valid_reg && cap_last_reg) begin
                busy <= 1'b0;
            end
        end
    end

    // Read data shows one edge after each accepted read strobe
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap_valid_reg <= 1'b0;
            cap_last_reg  <= 1'b0;
            cap_ptr_reg   <= 2'h0;
            read_done     <= 1'b0;
            read_empty    <= '0;
            read_full     <= '0;
        end else if (clk_en) begin
            cap_valid_reg <= state_reg == FOL_PREAD && !link.read_strobe_n;
            cap_last_reg  <= ptr_reg == hlast;
            cap_ptr_reg   <= ptr_reg;
            read_done     <= cap_valid_reg && cap_last_reg;
            if (cap_valid_reg) begin
                if (bus_width == FOL_W9) begin
                    case (cap_ptr_reg)
                        2'h0: read_empty[7:0]  <= link.output_bus[7:0];
                        2'h1: read_empty[14:8] <= link.output_bus[6:0];
                        2'h2: read_full[7:0]   <= link.output_bus[7:0];
                        default: read_full[14:8] <= link.output_bus[6:0];
                    endcase
                end else if (!cap_ptr_reg[0]) begin
                    if (cap_ptr_reg[1]) begin
                        read_full <= fol_unpack(link.output_bus, parity);
                    end else begin
                        read_empty <= fol_unpack(link.output_bus, parity);
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// [hw/fol_device.sv]
`include "fol_params.svh"
`default_nettype none

// How it works
// RULE_01 - Serial mode shifts one bit per edge
// RULE_02 - Full serial load is two offset widths
// RULE_03 - Each offset register holds fifteen bits
// RULE_04 - Unused bus lanes are ignored when loading
// RULE_05 - No selective serial load of one register
// RULE_06 - Flags invalid while a serial load runs
// RULE_07 - Serial reload accepted any time later
// RULE_08 - Enable high blocks serial shifting
// RULE_09 - Load high sends strobed words to memory
// RULE_10 - Resumed shifting continues at the next bit
// RULE_11 - Host pauses by raising one control
// RULE_12 - Full flag valid two edges after load
// RULE_13 - Empty flag valid two edges after load
// RULE_14 - Offsets read back only on output bus
// RULE_15 - Wide bus: one offset per cycle
// RULE_16 - Half bus: whole offset in the first of two cycles
// RULE_17 - Byte bus: four byte cycles per load
// RULE_18 - Parallel writes cycle empty, full, empty
// RULE_19 - Only master reset clears offset pointers
// RULE_20 - Programming method fixed at master reset
// RULE_21 - Serial counter wraps after the last bit

module fol_device (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                clk_en,
    input  wire logic                serial_mode_strap,
    input  wire fol_pkg::fol_width_t width_strap,
    input  wire logic                parity_strap,
    input  wire logic                partial_reset,
    input  wire logic [15:0]         fill_level,
    output logic                     almost_empty_flag_n,
    output logic                     almost_full_flag_n,
    output logic                     empty_flag_valid,
    output logic                     full_flag_valid,
    output logic                     mem_write,
    output fol_pkg::fol_bus_t        mem_word,
    fol_link_if.dev                  link
);
    import fol_pkg::*;

    fol_width_t  width_reg;
    logic        serial_mode_reg;
    logic        parity_reg;
    logic        straps_taken_reg;
    fol_ofs_t    empty_reg; // RULE_03
    fol_ofs_t    full_reg;
    logic [4:0]  ser_cnt_reg;
    logic [4:0]  ser_hi;
    logic        ser_last;
    logic [1:0]  wptr_reg;
    logic [1:0]  rptr_reg;
    logic [1:0]  ptr_inc;
    logic        active;
    logic        ser_shift;
    logic        par_write;
    logic        par_read;
    logic        mem_wr;
    logic        wide;
    logic [1:0]  touch;
    logic [1:0]  done;
    logic [1:0]  valid_reg;

    // Straps caught at the first enabled edge after release
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            straps_taken_reg <= 1'b0;
            serial_mode_reg  <= 1'b0;
            width_reg        <= FOL_W36;
            parity_reg       <= 1'b0;
        end else if (clk_en && !straps_taken_reg) begin
            straps_taken_reg <= 1'b1;
            serial_mode_reg  <= serial_mode_strap; // RULE_20
            width_reg        <= width_strap;
            parity_reg       <= parity_strap;
        end
    end

    assign active    = clk_en && straps_taken_reg;
    assign wide      = width_reg == FOL_W36;
    assign ptr_inc   = wide ? `FOL_PTR_INC36 : `FOL_PTR_INC;
    assign ser_last  = ser_cnt_reg == `FOL_SER_LAST; // RULE_02
    assign ser_hi    = ser_cnt_reg - `FOL_SER_HALF;

    // Shifts stay blocked while the write strobe is low, so a strobe never doubles as a shift
    assign ser_shift = active && serial_mode_reg && !link.load_select_n
                       && !link.shift_in_enable_n
                       && link.write_strobe_n; // RULE_08
    assign par_write = active && !serial_mode_reg && !link.load_select_n
                       && !link.write_strobe_n;
    assign par_read  = active && !link.load_select_n && !link.read_strobe_n;
    assign mem_wr    = active && link.load_select_n
                       && !link.write_strobe_n; // RULE_09

    // Count only moves on a real shift, so a pause resumes in place
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ser_cnt_reg <= 5'h00;
        end else if (ser_shift) begin
            ser_cnt_reg <= ser_last ? 5'h00 : ser_cnt_reg + 5'h01; // RULE_21
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            empty_reg <= `FOL_OFS_RST;
            full_reg  <= `FOL_OFS_RST;
        end else if (ser_shift) begin
            // Whole sequence only; each bit lands at its fixed place
            if (ser_cnt_reg < `FOL_SER_HALF) begin // RULE_01
                empty_reg[ser_cnt_reg[3:0]] <= link.shift_in_bit; // RULE_05
            end else begin
                full_reg[ser_hi[3:0]] <= link.shift_in_bit; // RULE_10
            end
        end else if (par_write) begin
            if (width_reg == FOL_W9) begin
                case (wptr_reg) // RULE_17
                    2'h0: empty_reg[7:0]  <= link.input_bus[7:0];
                    2'h1: empty_reg[14:8] <= link.input_bus[6:0];
                    2'h2: full_reg[7:0]   <= link.input_bus[7:0];
                    default: full_reg[14:8] <= link.input_bus[6:0];
                endcase
            end else if (!wptr_reg[0]) begin // RULE_04
                // Upper half-bus step carries only don't-care lanes
                if (wptr_reg[1]) begin
                    full_reg <= fol_unpack(link.input_bus,
                                           parity_reg); // RULE_15
                end else begin
                    empty_reg <= fol_unpack(link.input_bus,
                                            parity_reg); // RULE_16
                end
            end
        end
    end

    // Partial reset does not reach the pointers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wptr_reg <= 2'h0; // RULE_19
        end else if (par_write) begin
            wptr_reg <= wptr_reg + ptr_inc; // RULE_18
        end
    end

    // Read pointer steps like the write pointer but independently
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rptr_reg <= 2'h0; // RULE_19
        end else if (par_read) begin
            rptr_reg <= rptr_reg + ptr_inc;
        end
    end

    // Readback overwrites whatever word the port was showing
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.output_bus <= '0;
        end else if (par_read) begin
            link.output_bus <= fol_word(width_reg, parity_reg, rptr_reg,
                                        empty_reg, full_reg); // RULE_14
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_write <= 1'b0;
            mem_word  <= '0;
        end else if (clk_en && partial_reset) begin
            mem_write <= 1'b0;
        end else if (clk_en) begin
            mem_write <= mem_wr;
            if (mem_wr) begin
                mem_word <= link.input_bus;
            end
        end
    end

    // Index 0 is the empty-side flag, index 1 the full-side flag
    assign touch[0] = ser_shift || (par_write && !wptr_reg[1]); // RULE_06
    assign touch[1] = ser_shift || (par_write && wptr_reg[1]);
    assign done[0]  = (ser_shift && ser_last)
                      || (par_write && !wptr_reg[1]
                          && (wptr_reg[0] || wide)); // RULE_07
    assign done[1]  = (ser_shift && ser_last)
                      || (par_write && wptr_reg[1]
                          && (wptr_reg[0] || wide));

    // One clock serves both sides, so both flags share the latency
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_flag
            logic [`FOL_FLAG_LAT-1:0] pipe_reg;

            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pipe_reg       <= '0;
                    valid_reg[gi]  <= 1'b0;
                end else if (clk_en) begin
                    // A fresh load cancels a completion still in flight
                    pipe_reg[0] <= done[gi];
                    pipe_reg[1] <= pipe_reg[0] && !touch[gi];
                    if (pipe_reg[1] && !touch[gi]) begin
                        valid_reg[gi] <= 1'b1; // RULE_12
                    end else if (touch[gi]) begin
                        valid_reg[gi] <= 1'b0; // RULE_13
                    end
                end
            end
        end
    endgenerate

    assign empty_flag_valid = valid_reg[0];
    assign full_flag_valid  = valid_reg[1];

    // Invalid flags are held deasserted
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            almost_empty_flag_n <= 1'b1;
            almost_full_flag_n  <= 1'b1;
        end else if (clk_en) begin
            almost_empty_flag_n <= !(valid_reg[0]
                                     && fill_level <= {1'b0, empty_reg});
            almost_full_flag_n  <= !(valid_reg[1]
                                     && fill_level >= (`FOL_DEPTH
                                                       - {1'b0, full_reg}));
        end
    end

endmodule

`default_nettype wire

// [bench/fol_checker.sv]
`default_nettype none

module fol_checker (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    input wire logic        serial_mode_strap,
    input wire logic        load_select_n,
    input wire logic        shift_in_enable_n,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic [35:0] input_bus,
    input wire logic        empty_flag_valid,
    input wire logic        full_flag_valid,
    input wire logic        almost_empty_flag_n,
    input wire logic        almost_full_flag_n,
    input wire logic        mem_write,
    input wire logic [35:0] mem_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] bit_reg;
    logic       shift;
    logic       last;
    assign shift = serial_mode_strap & ~load_select_n & ~shift_in_enable_n
                 & write_strobe_n & clk_en;
    assign last = shift & (bit_reg == 5'h1D);
    // Mirrors the device's serial position so completion can be seen
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_reg <= 5'h00;
        end else if (shift) begin
            bit_reg <= last ? 5'h00 : bit_reg + 5'h01;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence load_done_s;
        last ##1 !shift [*2];
    endsequence
    mem_pulse_a: assert property (load_select_n && !write_strobe_n
        |=> mem_write && mem_word == $past(input_bus))
        else $error("memory word not stored");
    mem_cause_a: assert property (mem_write
        |-> $past(load_select_n && !write_strobe_n))
        else $error("memory write without strobe");
    shift_clear_a: assert property (shift
        |=> !empty_flag_valid && !full_flag_valid)
        else $error("flag valid during serial load");
    valid_late_a: assert property (load_done_s
        |=> empty_flag_valid && full_flag_valid)
        else $error("flags not valid after load");
    valid_cause_a: assert property (serial_mode_strap
        && $rose(full_flag_valid) |-> $past(last, 3))
        else $error("flag valid before full load");
    full_hidden_a: assert property (!full_flag_valid
        && !$past(full_flag_valid) |-> almost_full_flag_n)
        else $error("invalid full flag asserted");
    empty_hidden_a: assert property (!empty_flag_valid
        && !$past(empty_flag_valid) |-> almost_empty_flag_n)
        else $error("invalid empty flag asserted");
    serial_gate_a: assert property (!load_select_n
        && !shift_in_enable_n |-> write_strobe_n && read_strobe_n)
        else $error("strobe active while shifting");
    rdwr_excl_a: assert property (!load_select_n
        && !read_strobe_n |-> write_strobe_n)
        else $error("offset read and write together");
endmodule

`default_nettype wire

// [bench/fifo_flag_offset_loader_bench.sv]
`default_nettype none

module fifo_flag_offset_loader_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import fol_pkg::*;
    logic       ref_clk = 0, sys_rst = 1, mode = 1, par = 0, pause = 0;
    logic       ce = 1, prst = 0;
    logic [3:0] st = 4'h0;
    logic [15:0] fill = 16'h0000;
    fol_width_t wid = FOL_W36;
    fol_ofs_t   ev = '0, fv = '0, xe, xf, re, rf;
    fol_bus_t   md = '0, mw, lmw;
    logic       busy, rd, ev_ok, fv_ok, ae_n, af_n, mwr;
    int         seed = 32'h09E7, error_cnt = 0, checks = 0, cyc = 0, rdn = 0;

    fol_link_if link ();
    fol_host i_fol_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(ce),
        .bus_width(wid), .parity(par), .pause(pause), .start_serial(st[0]),
        .start_par_write(st[1]), .start_read(st[2]), .start_mem_write(st[3]),
        .empty_value(ev), .full_value(fv), .mem_data(md), .busy(busy),
        .read_done(rd), .read_empty(re), .read_full(rf), .link(link));
    fol_device i_fol_device (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clk_en(ce), .serial_mode_strap(mode), .width_strap(wid),
        .parity_strap(par), .partial_reset(prst), .fill_level(fill),
        .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n),
        .empty_flag_valid(ev_ok), .full_flag_valid(fv_ok),
        .mem_write(mwr), .mem_word(mw), .link(link));
    fol_checker i_fol_checker (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .serial_mode_strap(mode), .load_select_n(link.load_select_n),
        .shift_in_enable_n(link.shift_in_enable_n),
        .write_strobe_n(link.write_strobe_n), .clk_en(ce),
        .read_strobe_n(link.read_strobe_n), .input_bus(link.input_bus),
        .empty_flag_valid(ev_ok), .full_flag_valid(fv_ok),
        .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n),
        .mem_write(mwr), .mem_word(mw));

    initial forever #5 ref_clk = ~ref_clk;

    // Pulse is one cycle wide, so it is captured where it stands
    always @(posedge ref_clk) begin
        cyc++;
        if (mwr) begin
            lmw = mw;
        end
        if (rd) begin
            rdn++;
        end
        if (cyc == 30000) begin
            error_cnt++;
            stop_test();
        end
    end

    function automatic logic [1:0] fx(input logic [15:0] v);
        fx = {v > 16'(xe), v < 16'h8000 - 16'(xf)};
    endfunction

    task automatic stop_test();
        $display("Checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic go(input int s);
        int n;
        @(negedge ref_clk);
        st[s] = 1'b1;
        @(negedge ref_clk);
        st[s] = 1'b0;
        if (s == 1) begin
            prst = 1'b1;
            @(negedge ref_clk);
            prst = 1'b0;
        end
        if (s == 0) begin
            repeat (8) @(negedge ref_clk);
            pause = 1'b1;
            repeat (4) @(negedge ref_clk);
            if (mode) chk(ev_ok | fv_ok, 0);
            pause = 1'b0;
            repeat (2) @(negedge ref_clk);
            // Freeze while shifting; an extra device shift breaks readback
            ce = 1'b0;
            repeat (3) @(negedge ref_clk);
            ce = 1'b1;
        end
        for (n = 0; n < 200 && busy !== 1'b0; n++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic mres(input logic m, input fol_width_t w, input logic p);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        mode = m;
        wid = w;
        par = p;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic load(input int s, input logic [29:0] v, input logic ok);
        logic [15:0] fl [4];
        {ev, fv} = v;
        if (ok) {xe, xf} = v;
        go(s);
        chk({ev_ok, fv_ok}, 2'h3);
        rdn = 0;
        go(2);
        chk(rdn, 1);
        chk(re, xe);
        chk(rf, xf);
        fl = '{16'(xe), 16'(xe) + 16'h1, 16'h8000 - 16'(xf),
               16'h7FFF - 16'(xf)};
        foreach (fl[i]) begin
            fill = fl[i];
            repeat (3) @(negedge ref_clk);
            chk({ae_n, af_n}, fx(fill));
        end
    endtask

    initial begin
        mres(1'b1, FOL_W36, 1'b0);
        load(0, {15'h7FFF, 15'h0001}, 1'b1);
        load(0, 30'($random(seed)), 1'b1);
        md = {4'hA, 32'($random(seed))};
        go(3);
        chk(lmw, md);
        for (int w = 0; w < 6; w++) begin
            mres(1'b0, fol_width_t'(w >> 1), w[0]);
            load(1, 30'($random(seed)), 1'b1);
            load(0, 30'($random(seed)), 1'b0);
        end
        stop_test();
    end
endmodule

`default_nettype wire
